// file: port_ctl.sv
// port controller for one transmitting and one receiving daughter card port
`timescale 1ns/1ps
`include "port_ctl_defines.svh"

// Summary of operation
// - transmit port drives 27 data lines from transmit pattern storage.
// - receive port stores 27 card-driven data lines into receive storage.
// - all port logic runs on the single board system clock.
// - status line 2 carries clock info; a mode bit selects card clock.
// - card master reset low during power-up, button or software reset.
// - 9 I/O lines per port, direction from one mode bit per port.
// - transmit I/O as input feeds response FIFO; I/O driver disabled.
// - three handshake control lines driven, three status lines sampled.
// - status lines encoded and reported in the status register.
// - per-port active-low control line and mode line mirror register bits.
// - report line 0 means ready/good, line 1 means bad/error.
// - two broadcast control bits go to every port at once.
// - receive data bits 26,25 and I/O bits 8,7 reach the controller.
// - transmit data bits 26,25 and I/O bits 8,7 reach the controller.
// - receiving stores one word every cycle; valid-only storing optional.
// - transmit data bit 26 high ends the pattern and stops transmission.
// - transmit up to 26 payload bits, 35 with I/O, up to 53 MHz.
// - receive up to 27 bits, 36 with I/O, up to 53 MHz.
// - main and I/O transmit FIFOs share one read strobe.
// - main and extension receive FIFOs share one write strobe.
module port_ctl
   import port_ctl_pkg::*;
#(
   parameter int DATA_W = 27,
   parameter int IO_W   = 9
) (
   // clock, reset, enable
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                ce,
   // register port
   input  wire logic [`ADDR_W-1:0]  reg_addr,
   input  wire logic [`REG_W-1:0]   reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [`REG_W-1:0]        reg_rdata_r,
   // common card lines
   output logic                     card_reset_n_r,
   output logic [1:0]               broadcast_ctrl_bits_r,
   output logic                     clk_follow_sel_r,
   // transmit FIFOs (main and I/O half a)
   output logic                     tx_fifo_rd_r,
   input  wire logic [DATA_W-1:0]   tx_main_fifo_data,
   input  wire logic                tx_main_fifo_empty,
   input  wire logic [IO_W-1:0]     tx_io_fifo_a_data,
   // transmit response FIFO
   output logic                     tx_response_fifo_wr_r,
   output logic [IO_W-1:0]          tx_response_fifo_data_r,
   input  wire logic                tx_response_fifo_full,
   // transmit port connector
   output logic [DATA_W-1:0]        tx_pattern_lines_r,
   input  wire logic [IO_W-1:0]     tx_io_in,
   output logic [IO_W-1:0]          tx_io_out_r,
   output logic                     tx_io_oe_n_r,
   output logic [2:0]               tx_hsk_ctrl_r,
   input  wire logic [2:0]          tx_hsk_status,
   output logic                     tx_port_user_ctrl_n_r,
   output logic                     tx_port_user_cfg_r,
   input  wire logic [1:0]          tx_card_report_lines,
   // receive FIFOs (main and extension)
   output logic                     rx_fifo_wr_r,
   output logic [DATA_W-1:0]        rx_main_fifo_data_r,
   output logic [IO_W-1:0]          rx_extension_fifo_data_r,
   input  wire logic                rx_main_fifo_full,
   // I/O source for the receive port (I/O half b)
   output logic                     rx_io_src_rd_r,
   input  wire logic [IO_W-1:0]     rx_io_src_data,
   input  wire logic                rx_io_src_empty,
   // receive port connector
   input  wire logic [DATA_W-1:0]   rx_capture_lines,
   input  wire logic [IO_W-1:0]     rx_io_in,
   output logic [IO_W-1:0]          rx_io_out_r,
   output logic                     rx_io_oe_n_r,
   output logic [2:0]               rx_hsk_ctrl_r,
   input  wire logic [2:0]          rx_hsk_status,
   output logic                     rx_port_user_ctrl_n_r,
   output logic                     rx_port_user_cfg_r,
   input  wire logic [1:0]          rx_card_report_lines
);

   // elaboration checks
   generate
      if (DATA_W != 27 || IO_W != 9) begin : g_bad_width
         $error("port_ctl serves only 27 data and 9 I/O lines");
      end
      if (`CLK_PERIOD_NS < `MIN_PERIOD_NS) begin : g_bad_rate
         $error("port_ctl clock faster than the port allows");
      end
   endgenerate

   // report encoding: ready when line 0 and not line 1, error on line 1
   function automatic logic [1:0] encode_report(input logic [1:0] lines);
      encode_report = {lines[1], lines[0] & ~lines[1]};
   endfunction

   function automatic upper_bits_s take_upper(input logic [DATA_W-1:0] d,
                                              input logic [IO_W-1:0]   io);
      take_upper.data_top = d[DATA_W-1:DATA_W-2];
      take_upper.io_top   = io[IO_W-1:IO_W-2];
   endfunction

   // state
   logic [`REG_W-1:0] ctrl_r;
   logic [`REG_W-1:0] mode_r;
   tx_state_e         tx_state_r;
   tx_state_e         tx_state_nxt;
   rx_state_e         rx_state_r;
   rx_state_e         rx_state_nxt;
   logic              tx_end_r;
   logic              rx_ovf_r;
   upper_bits_s       tx_upper_r;
   upper_bits_s       rx_upper_r;

   // register decode
   wire         wr_ctrl   = reg_wr && (reg_addr == `OFS_CTRL);
   wire         wr_mode   = reg_wr && (reg_addr == `OFS_MODE);
   wire         soft_rst  = ctrl_r[`CTRL_SW_RESET];
   wire         tx_go     = wr_ctrl && reg_wdata[`CTRL_TX_START];
   wire         tx_halt   = wr_ctrl && reg_wdata[`CTRL_TX_STOP];
   wire         rx_go     = wr_ctrl && reg_wdata[`CTRL_RX_START];
   wire         rx_halt   = wr_ctrl && reg_wdata[`CTRL_RX_STOP];
   wire         tx_io_in_mode  = mode_r[`MODE_TX_IO_IN];
   wire         rx_io_out_mode = mode_r[`MODE_RX_IO_OUT];
   wire         valid_only     = ctrl_r[`CTRL_RX_VALID_ONLY];

   // status word
   card_stat_s  tx_stat;
   card_stat_s  rx_stat;
   assign tx_stat.hsk    = tx_hsk_status;
   assign tx_stat.report = encode_report(tx_card_report_lines);
   assign rx_stat.hsk    = rx_hsk_status;
   assign rx_stat.report = encode_report(rx_card_report_lines);

   logic [`REG_W-1:0] status_word;
   always_comb begin
      status_word = '0;
      status_word[`ST_TX_RPT_LO +: 2] = tx_stat.report;
      status_word[`ST_RX_RPT_LO +: 2] = rx_stat.report;
      status_word[`ST_TX_BUSY]        = (tx_state_r == TX_RUN);
      status_word[`ST_RX_BUSY]        = (rx_state_r == RX_RUN);
      status_word[`ST_TX_END]         = tx_end_r;
      status_word[`ST_RX_OVF]         = rx_ovf_r;
      status_word[`ST_TX_HSK_LO +: 3] = tx_stat.hsk;
      status_word[`ST_RX_HSK_LO +: 3] = rx_stat.hsk;
      status_word[`ST_TX_UPPER_LO +: 4] = tx_upper_r;
      status_word[`ST_RX_UPPER_LO +: 4] = rx_upper_r;
      status_word[`ST_CLK_REQ]        = rx_hsk_status[2] | tx_hsk_status[2];
   end

   wire [`REG_W-1:0] rd_mux =
      (reg_addr == `OFS_CTRL)   ? ctrl_r :
      (reg_addr == `OFS_MODE)   ? mode_r :
      (reg_addr == `OFS_STATUS) ? status_word : '0;

   // transmit datapath decisions
   wire tx_running = (tx_state_r == TX_RUN);
   wire tx_take    = tx_fifo_rd_r && !tx_main_fifo_empty;
   wire tx_mark    = tx_take && tx_main_fifo_data[`END_MARK_BIT];
   wire tx_issue   = tx_running && !tx_main_fifo_empty && !tx_mark &&
                     !tx_halt && !soft_rst;
   wire tx_resp_wr = tx_running && tx_io_in_mode && tx_io_oe_n_r &&
                     !tx_response_fifo_full;

   // receive datapath decisions
   wire rx_running = (rx_state_r == RX_RUN);
   wire rx_valid   = rx_capture_lines[`VALID_BIT_A] | rx_capture_lines[`VALID_BIT_B];
   wire rx_store   = rx_running && !rx_main_fifo_full && (!valid_only || rx_valid);
   wire rx_lost    = rx_running && rx_main_fifo_full && (!valid_only || rx_valid);
   wire rx_io_rd   = rx_running && rx_io_out_mode && !rx_io_src_empty;

   // transmit sequencer
   always_comb begin
      tx_state_nxt = tx_state_r;
      case (tx_state_r)
         TX_IDLE: begin
            if (tx_go) begin
               tx_state_nxt = TX_RUN;
            end
         end
         TX_RUN: begin
            if (soft_rst || tx_halt) begin
               tx_state_nxt = TX_IDLE;
            end else if (tx_mark) begin
               tx_state_nxt = TX_END;
            end
         end
         TX_END: begin
            if (tx_go) begin
               tx_state_nxt = TX_RUN;
            end else if (soft_rst) begin
               tx_state_nxt = TX_IDLE;
            end
         end
         default: tx_state_nxt = TX_IDLE;
      endcase
   end

   // receive sequencer
   always_comb begin
      rx_state_nxt = rx_state_r;
      case (rx_state_r)
         RX_IDLE: begin
            if (rx_go) begin
               rx_state_nxt = RX_RUN;
            end
         end
         RX_RUN: begin
            if (soft_rst) begin
               rx_state_nxt = RX_IDLE;
            end else if (rx_halt) begin
               rx_state_nxt = RX_HALT;
            end
         end
         RX_HALT: begin
            if (rx_go) begin
               rx_state_nxt = RX_RUN;
            end else if (soft_rst) begin
               rx_state_nxt = RX_IDLE;
            end
         end
         default: rx_state_nxt = RX_IDLE;
      endcase
   end

   // registers and sequencer state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r     <= `CTRL_RESET_VAL;
         mode_r     <= `MODE_RESET_VAL;
         tx_state_r <= TX_IDLE;
         rx_state_r <= RX_IDLE;
         tx_end_r   <= 1'b0;
         rx_ovf_r   <= 1'b0;
      end else if (ce) begin
         if (wr_ctrl) begin
            ctrl_r <= reg_wdata & `CTRL_STORE_MASK;
         end
         if (wr_mode) begin
            mode_r <= reg_wdata & `MODE_STORE_MASK;
         end
         tx_state_r <= tx_state_nxt;
         rx_state_r <= rx_state_nxt;
         tx_end_r   <= tx_mark | (tx_end_r & ~tx_go);
         rx_ovf_r   <= rx_lost | (rx_ovf_r & ~rx_go);
      end
   end

   // register read data and card control lines
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r           <= '0;
         card_reset_n_r        <= 1'b0;
         broadcast_ctrl_bits_r <= 2'h0;
         clk_follow_sel_r      <= 1'b0;
         tx_hsk_ctrl_r         <= 3'h0;
         rx_hsk_ctrl_r         <= 3'h0;
         tx_port_user_ctrl_n_r <= 1'b1;
         rx_port_user_ctrl_n_r <= 1'b1;
         tx_port_user_cfg_r    <= 1'b0;
         rx_port_user_cfg_r    <= 1'b0;
      end else if (ce) begin
         reg_rdata_r    <= reg_rd ? rd_mux : '0;
         card_reset_n_r <= wr_ctrl ? ~reg_wdata[`CTRL_SW_RESET] : ~soft_rst;
         if (wr_ctrl) begin
            broadcast_ctrl_bits_r <= reg_wdata[`CTRL_BCAST_LO +: 2];
            tx_hsk_ctrl_r         <= reg_wdata[`CTRL_TX_HSK_LO +: 3];
            rx_hsk_ctrl_r         <= reg_wdata[`CTRL_RX_HSK_LO +: 3];
            tx_port_user_ctrl_n_r <= ~reg_wdata[`CTRL_TX_UCTRL];
            rx_port_user_ctrl_n_r <= ~reg_wdata[`CTRL_RX_UCTRL];
         end
         if (wr_mode) begin
            tx_port_user_cfg_r <= reg_wdata[`MODE_TX_UCFG];
            rx_port_user_cfg_r <= reg_wdata[`MODE_RX_UCFG];
            clk_follow_sel_r   <= reg_wdata[`MODE_CLK_FOLLOW];
         end
      end
   end

   // transmit port datapath
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_fifo_rd_r            <= 1'b0;
         tx_pattern_lines_r      <= '0;
         tx_io_out_r             <= '0;
         tx_io_oe_n_r            <= 1'b1;
         tx_response_fifo_wr_r   <= 1'b0;
         tx_response_fifo_data_r <= '0;
         tx_upper_r              <= '0;
      end else if (ce) begin
         tx_fifo_rd_r <= tx_issue;
         if (tx_take) begin
            tx_pattern_lines_r <= tx_main_fifo_data;
            tx_io_out_r        <= tx_io_fifo_a_data;
         end
         tx_io_oe_n_r            <= tx_io_in_mode;
         tx_response_fifo_wr_r   <= tx_resp_wr;
         tx_response_fifo_data_r <= tx_io_in;
         tx_upper_r <= take_upper(tx_pattern_lines_r,
                                  tx_io_in_mode ? tx_io_in : tx_io_out_r);
      end
   end

   // receive port datapath
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_fifo_wr_r             <= 1'b0;
         rx_main_fifo_data_r      <= '0;
         rx_extension_fifo_data_r <= '0;
         rx_io_src_rd_r           <= 1'b0;
         rx_io_out_r              <= '0;
         rx_io_oe_n_r             <= 1'b1;
         rx_upper_r               <= '0;
      end else if (ce) begin
         rx_fifo_wr_r             <= rx_store;
         rx_main_fifo_data_r      <= rx_capture_lines;
         rx_extension_fifo_data_r <= rx_io_out_mode ? '0 : rx_io_in;
         rx_io_src_rd_r           <= rx_io_rd;
         if (rx_io_src_rd_r) begin
            rx_io_out_r <= rx_io_src_data;
         end
         rx_io_oe_n_r <= ~rx_io_out_mode;
         rx_upper_r   <= take_upper(rx_capture_lines,
                                    rx_io_out_mode ? rx_io_out_r : rx_io_in);
      end
   end

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_tx_start;
      ce && tx_go && !soft_rst;
   endsequence

   sequence s_status_read;
      ce && reg_rd && (reg_addr == `OFS_STATUS);
   endsequence

   sequence s_end_word;
      ce && tx_take && tx_main_fifo_data[`END_MARK_BIT] && !tx_halt && !soft_rst;
   endsequence

   a_card_reset_sw: assert property (ce && wr_ctrl && reg_wdata[`CTRL_SW_RESET]
      |=> !card_reset_n_r) else $error("card reset not asserted");
   a_tx_end_stop: assert property (s_end_word |=> !tx_fifo_rd_r ##0 tx_state_r == TX_END)
      else $error("transmit did not stop on end marker");
   a_tx_no_empty: assert property (ce && tx_main_fifo_empty |=> !tx_fifo_rd_r)
      else $error("transmit read from empty fifo");
   a_tx_word_out: assert property (ce && tx_take |=>
      tx_pattern_lines_r == $past(tx_main_fifo_data) &&
      tx_io_out_r == $past(tx_io_fifo_a_data)) else $error("transmit word lost");
   a_tx_go_busy: assert property (s_tx_start ##1 ce && !tx_main_fifo_empty && !soft_rst
      |=> tx_fifo_rd_r) else $error("transmit did not start reading");
   a_rx_each_cycle: assert property (ce && rx_running && !valid_only && !rx_main_fifo_full
      |=> rx_fifo_wr_r && rx_main_fifo_data_r == $past(rx_capture_lines))
      else $error("receive word not stored");
   a_rx_ext_paired: assert property (ce && rx_running && !rx_io_out_mode && rx_store
      |=> rx_fifo_wr_r && rx_extension_fifo_data_r == $past(rx_io_in))
      else $error("extension word not paired");
   a_io_no_fight: assert property (tx_response_fifo_wr_r |-> tx_io_oe_n_r &&
      $past(tx_io_oe_n_r))
      else $error("response capture while driving");
   a_status_code: assert property (s_status_read |=>
      reg_rdata_r[`ST_TX_RPT_LO +: 2] == encode_report($past(tx_card_report_lines)))
      else $error("status report encoding wrong");
   a_user_ctrl: assert property (ce && wr_ctrl |=>
      tx_port_user_ctrl_n_r == !$past(reg_wdata[`CTRL_TX_UCTRL]) &&
      broadcast_ctrl_bits_r == $past(reg_wdata[`CTRL_BCAST_LO +: 2]))
      else $error("user control lines not mirrored");

endmodule

// file: port_ctl_defines.svh
// register offsets, field positions and timing counts for the port controller
`ifndef PORT_CTL_DEFINES_SVH
`define PORT_CTL_DEFINES_SVH
`define ADDR_W             8
`define REG_W              32
`define OFS_CTRL           8'h10
`define OFS_MODE           8'h20
`define OFS_STATUS         8'h30
`define CTRL_SW_RESET      0
`define CTRL_TX_START      1
`define CTRL_RX_START      2
`define CTRL_RX_STOP       3
`define CTRL_TX_UCTRL      4
`define CTRL_RX_UCTRL      5
`define CTRL_BCAST_LO      6
`define CTRL_TX_HSK_LO     8
`define CTRL_RX_HSK_LO     11
`define CTRL_RX_VALID_ONLY 14
`define CTRL_TX_STOP       15
`define CTRL_STORE_MASK    32'h0000_7ff1
`define CTRL_RESET_VAL     32'h0000_0000
`define MODE_TX_IO_IN      0
`define MODE_RX_IO_OUT     1
`define MODE_TX_UCFG       2
`define MODE_RX_UCFG       3
`define MODE_CLK_FOLLOW    4
`define MODE_STORE_MASK    32'h0000_001f
`define MODE_RESET_VAL     32'h0000_0000
`define ST_TX_RPT_LO       0
`define ST_RX_RPT_LO       2
`define ST_TX_BUSY         4
`define ST_RX_BUSY         5
`define ST_TX_END          6
`define ST_RX_OVF          7
`define ST_TX_HSK_LO       8
`define ST_RX_HSK_LO       11
`define ST_TX_UPPER_LO     14
`define ST_RX_UPPER_LO     18
`define ST_CLK_REQ         22
`define END_MARK_BIT       26
`define VALID_BIT_A        25
`define VALID_BIT_B        26
`define CLK_PERIOD_NS      50
`define MAX_RATE_MHZ       53
`define MIN_PERIOD_NS      ((1000 + `MAX_RATE_MHZ - 1) / `MAX_RATE_MHZ)
`endif

// file: port_ctl_pkg.sv
// types shared by the port controller
package port_ctl_pkg;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_RUN  = 2'b01,
      TX_END  = 2'b11
   } tx_state_e;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_RUN  = 2'b01,
      RX_HALT = 2'b11
   } rx_state_e;
   typedef struct packed {
      logic [2:0] hsk;
      logic       user_ctrl;
      logic       user_cfg;
   } card_ctrl_s;
   typedef struct packed {
      logic [2:0] hsk;
      logic [1:0] report;
   } card_stat_s;
   typedef struct packed {
      logic [1:0] data_top;
      logic [1:0] io_top;
   } upper_bits_s;
endpackage

// file: daughter_card.sv
// behavioural daughter cards on the transmit and receive ports
`timescale 1ns/1ps
module daughter_card (
   // board side
   input  wire logic        ref_clk,
   input  wire logic        card_reset_n,
   input  wire logic [2:0]  tx_hsk_ctrl,
   input  wire logic [2:0]  rx_hsk_ctrl,
   input  wire logic        tx_io_oe_n,
   input  wire logic [8:0]  tx_io_out,
   input  wire logic        rx_io_oe_n,
   input  wire logic [8:0]  rx_io_out,
   // scenario controls
   input  wire logic        run,
   input  wire logic [26:0] idle_word,
   input  wire logic [1:0]  rpt,
   // card outputs
   output logic [26:0]      rx_capture_lines,
   output logic [8:0]       rx_io_in,
   output logic [8:0]       tx_io_in,
   output logic [2:0]       tx_hsk_status,
   output logic [2:0]       rx_hsk_status,
   output logic [1:0]       tx_card_report_lines,
   output logic [1:0]       rx_card_report_lines
);
   logic [26:0] cnt_r;
   // stream source on the board clock, cleared by master reset
   always_ff @(posedge ref_clk or negedge card_reset_n) begin
      if (!card_reset_n) cnt_r <= 27'h000_0000;
      else if (run) cnt_r <= cnt_r + 27'h2b5_c3f1;
   end
   assign rx_capture_lines     = run ? cnt_r : idle_word;
   assign rx_io_in             = rx_io_oe_n ? (run ? cnt_r[8:0] : 9'h0a5) : rx_io_out;
   assign tx_io_in             = tx_io_oe_n ? 9'h1c3 : tx_io_out;
   assign tx_hsk_status        = card_reset_n ? tx_hsk_ctrl : 3'h0;
   assign rx_hsk_status        = card_reset_n ? rx_hsk_ctrl : 3'h0;
   assign tx_card_report_lines = card_reset_n ? rpt : 2'h0;
   assign rx_card_report_lines = card_reset_n ? {rpt[0], rpt[1]} : 2'h0;
endmodule

// file: test_port_daughter_card_interface.sv
// self-checking bench for the port controller with card model
`timescale 1ns/1ps
`include "port_ctl_defines.svh"
module test_port_daughter_card_interface;
   logic        ref_clk, rst_n, reg_wr, reg_rd, tx_main_fifo_empty, rx_main_fifo_full;
   logic        run, vonly, ioin, card_reset_n_r, clk_follow_sel_r, tx_fifo_rd_r;
   logic        tx_response_fifo_wr_r, tx_io_oe_n_r, tx_port_user_ctrl_n_r, tx_port_user_cfg_r;
   logic        rx_fifo_wr_r, rx_io_oe_n_r, rx_port_user_ctrl_n_r, rx_port_user_cfg_r;
   logic        rd_prev = 1'b0;
   logic        pop;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata_r, rdv;
   logic [26:0] tx_main_fifo_data, tx_pattern_lines_r, rx_capture_lines, rx_main_fifo_data_r;
   logic [26:0] idle_word, cap_prev;
   logic [8:0]  tx_io_fifo_a_data, tx_io_in, tx_io_out_r, tx_response_fifo_data_r;
   logic [8:0]  rx_io_in, rx_io_out_r, rx_extension_fifo_data_r, io_prev;
   logic [2:0]  tx_hsk_ctrl_r, tx_hsk_status, rx_hsk_ctrl_r, rx_hsk_status;
   logic [1:0]  broadcast_ctrl_bits_r, tx_card_report_lines, rx_card_report_lines, rpt;
   logic [3:0]  wend;
   logic [35:0] txq[$], exq[$], w, e;
   int          n_fail, num_checks, n_rd, n_wr, n_rsp, cyc, k, base;

   port_ctl port_ctl_inst (.ref_clk, .rst_n, .ce(1'b1), .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata_r, .card_reset_n_r, .broadcast_ctrl_bits_r, .clk_follow_sel_r,
      .tx_fifo_rd_r, .tx_main_fifo_data, .tx_main_fifo_empty, .tx_io_fifo_a_data,
      .tx_response_fifo_wr_r, .tx_response_fifo_data_r, .tx_response_fifo_full(1'b0),
      .tx_pattern_lines_r, .tx_io_in, .tx_io_out_r, .tx_io_oe_n_r, .tx_hsk_ctrl_r,
      .tx_hsk_status, .tx_port_user_ctrl_n_r, .tx_port_user_cfg_r, .tx_card_report_lines,
      .rx_fifo_wr_r, .rx_main_fifo_data_r, .rx_extension_fifo_data_r, .rx_main_fifo_full,
      .rx_io_src_rd_r(), .rx_io_src_data(9'h000), .rx_io_src_empty(1'b1), .rx_capture_lines,
      .rx_io_in, .rx_io_out_r, .rx_io_oe_n_r, .rx_hsk_ctrl_r, .rx_hsk_status,
      .rx_port_user_ctrl_n_r, .rx_port_user_cfg_r, .rx_card_report_lines);
   daughter_card daughter_card_inst (.ref_clk, .card_reset_n(card_reset_n_r),
      .tx_hsk_ctrl(tx_hsk_ctrl_r), .rx_hsk_ctrl(rx_hsk_ctrl_r), .tx_io_oe_n(tx_io_oe_n_r),
      .tx_io_out(tx_io_out_r), .rx_io_oe_n(rx_io_oe_n_r), .rx_io_out(rx_io_out_r), .run,
      .idle_word, .rpt, .rx_capture_lines, .rx_io_in, .tx_io_in, .tx_hsk_status,
      .rx_hsk_status,
      .tx_card_report_lines, .rx_card_report_lines);

   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 rdv = reg_rdata_r;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      rd(a);
      check(rdv & m, x, "register read");
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // transmit FIFO model and port monitors
   always @(posedge ref_clk) begin
      pop = (tx_fifo_rd_r === 1'b1) && (txq.size() > 0);
      if (pop) e = txq.pop_front();
      if (txq.size() > 0) {tx_io_fifo_a_data, tx_main_fifo_data} <= txq[0];
      tx_main_fifo_empty <= (txq.size() == 0);
      if (rd_prev) begin
         e = exq.pop_front();
         check(tx_pattern_lines_r, e[26:0], "pattern word");
         if (!ioin) check(tx_io_out_r, e[35:27], "io word");
      end
      rd_prev <= pop;
      n_rd += pop;
      if (rx_fifo_wr_r === 1'b1) begin
         n_wr++;
         check(rx_main_fifo_data_r, cap_prev, "rx main word");
         check(rx_extension_fifo_data_r, io_prev, "rx ext word");
         if (vonly) check(cap_prev[26:25] != 2'b00, 1, "valid only");
      end
      cap_prev <= rx_capture_lines;
      io_prev <= rx_io_in;
      if (tx_response_fifo_wr_r === 1'b1) begin
         n_rsp++;
         check(tx_response_fifo_data_r, 9'h1c3, "response word");
      end
      cyc++;
      if (cyc > 4000) begin
         n_fail++;
         complete_run();
      end
   end

   initial begin
      rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
      run = 1'b0; vonly = 1'b0; ioin = 1'b0; idle_word = 27'h400_0000; rpt = 2'b01;
      rdv = 32'h0;
      rx_main_fifo_full = 1'b0; tx_main_fifo_empty = 1'b1;
      tx_main_fifo_data = 27'h0; tx_io_fifo_a_data = 9'h0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk(`OFS_CTRL, 32'hffff_ffff, 32'h0);
      rd_chk(`OFS_MODE, 32'hffff_ffff, 32'h0);
      check(card_reset_n_r, 1, "master reset released");
      wr(`OFS_CTRL, 32'h1);
      rd_chk(`OFS_STATUS, 32'h3, 32'h0);
      check(card_reset_n_r, 0, "software reset");
      wr(`OFS_CTRL, 32'h0);
      rd_chk(`OFS_STATUS, 32'h3, 32'h1);
      check(card_reset_n_r, 1, "software reset end");
      $display("test reset done");
      wr(`OFS_CTRL, 32'h1db0);
      wr(`OFS_MODE, 32'h1c);
      rd_chk(`OFS_CTRL, 32'hffff_ffff, 32'h1db0);
      rd_chk(`OFS_STATUS, 32'h7f_ff0f, 32'h64_1d09);
      check({tx_port_user_ctrl_n_r, rx_port_user_ctrl_n_r}, 2'b00, "user ctrl");
      check({tx_port_user_cfg_r, rx_port_user_cfg_r}, 2'b11, "user cfg");
      check(broadcast_ctrl_bits_r, 2'b10, "broadcast bits");
      check({tx_hsk_ctrl_r, rx_hsk_ctrl_r}, 6'b101011, "handshake out");
      check(clk_follow_sel_r, 1, "clock follow select");
      rpt <= 2'b11;
      rd_chk(`OFS_STATUS, 32'hf, 32'ha);
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_MODE, 32'h0);
      check(tx_port_user_ctrl_n_r, 1, "user ctrl idle");
      $display("test control lines done");
      for (k = 0; k < 4; k++) begin
         w = {9'h181 + 9'(k), 27'h02a_5a5a + 27'(k)};
         w[26] = (k == 2);
         w[25] = k[0];
         txq.push_back(w);
         if (k < 3) exq.push_back(w);
         if (k == 2) wend = {1'b1, w[25], w[35:34]};
      end
      base = n_rd;
      wr(`OFS_CTRL, 32'h2);
      rdv = 32'h0;
      for (k = 0; k < 20 && rdv[6] !== 1'b1; k++) rd(`OFS_STATUS);
      check(n_rd - base, 3, "reads up to end marker");
      check(exq.size(), 0, "all words sent");
      check(rdv[17:14], wend, "tx upper bits");
      check(tx_io_oe_n_r, 0, "tx io driving");
      exq.push_back(txq[0]);
      base = n_rd;
      wr(`OFS_CTRL, 32'h2);
      repeat (10) @(posedge ref_clk);
      check(n_rd - base, 1, "stop on empty");
      rd_chk(`OFS_STATUS, 32'h40, 32'h0);
      $display("test transmit done");
      wr(`OFS_MODE, 32'h1);
      ioin = 1'b1;
      for (k = 0; k < 3; k++) begin
         txq.push_back({9'h0, 27'h11 + 27'(k)});
         exq.push_back({9'h0, 27'h11 + 27'(k)});
      end
      base = n_rsp;
      wr(`OFS_CTRL, 32'h2);
      repeat (10) @(posedge ref_clk);
      check(tx_io_oe_n_r, 1, "tx io released");
      check(n_rsp > base, 1, "response stored");
      wr(`OFS_MODE, 32'h0);
      ioin = 1'b0;
      $display("test io input done");
      run <= 1'b1;
      base = n_wr;
      wr(`OFS_CTRL, 32'h4);
      repeat (12) @(posedge ref_clk);
      wr(`OFS_CTRL, 32'h8);
      check(n_wr - base >= 12, 1, "word every cycle");
      repeat (3) @(posedge ref_clk);
      vonly <= 1'b1;
      base = n_wr;
      wr(`OFS_CTRL, 32'h4004);
      repeat (20) @(posedge ref_clk);
      wr(`OFS_CTRL, 32'h8);
      repeat (3) @(posedge ref_clk);
      vonly <= 1'b0;
      check(n_wr > base, 1, "valid words stored");
      rx_main_fifo_full <= 1'b1;
      wr(`OFS_CTRL, 32'h4);
      base = n_wr;
      repeat (8) @(posedge ref_clk);
      check(n_wr - base, 0, "no write when full");
      rd_chk(`OFS_STATUS, 32'h80, 32'h80);
      wr(`OFS_CTRL, 32'h8);
      rx_main_fifo_full <= 1'b0;
      wr(`OFS_CTRL, 32'h4);
      rd_chk(`OFS_STATUS, 32'h80, 32'h0);
      wr(`OFS_CTRL, 32'h8);
      run <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd_chk(`OFS_STATUS, 32'h3c_0000, 32'h24_0000);
      $display("test receive done");
      complete_run();
   end
endmodule
